/* File: dv/dlb_partner.sv */
// outside circuits on the terminals
module dlb_partner
(
	// bank drive and outside level
	input wire [22:0] drv_i,
	input wire [22:0] oe_i,
	input wire [22:0] ext_i,
	// terminal level
	output wire [22:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// bank drive wins, else the outside level shows
	assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // dlb_partner

/* File: dv/dlb_props.sv */
// port assertions for the digital line bank
module dlb_props
(
	// clock and reset
	input wire clock_i,
	input wire reset_i,
	// strap and register port
	input wire reduced_i,
	input wire req_i,
	input wire wr_i,
	input wire [15:0] addr_i,
	input wire [31:0] wdata_i,
	input wire ack_o,
	input wire err_o,
	input wire [31:0] rdata_o,
	// analog channel and lines
	input wire ain_active_i,
	input wire [6:0] ain_channel_i,
	input wire [22:0] line_i,
	input wire [22:0] line_o,
	input wire [22:0] line_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// line index and written level of a single-line access
	wire [15:0] line_idx = addr_i - 16'h07D0;
	wire level_bit = wdata_i[0];
	a_ack_one_late: assert property (1 |=> ack_o == $past(req_i)) else $error("ack timing");
	a_err_with_ack: assert property (err_o |-> ack_o) else $error("err without ack");
	a_rdata_idle_zero: assert property (!ack_o |-> rdata_o == 32'h0) else $error("stray rdata");
	a_line_write_drives: assert property (req_i && wr_i && addr_i >= 16'h07D4 && addr_i <= 16'h07E3
		|=> line_oe_o[$past(line_idx)] && line_o[$past(line_idx)] == $past(level_bit))
		else $error("single line write");
	a_port_keeps_dir: assert property (req_i && wr_i && addr_i[15:2] == 14'h0271
		|=> $stable(line_oe_o[19:4])) else $error("port write moved direction");
	a_reduced_no_drive: assert property (reduced_i [*3]
		|-> line_oe_o[3:0] == 4'h0 && line_oe_o[22:20] == 3'h0) else $error("reduced drive");
	a_mux_steers: assert property ((ain_active_i && ain_channel_i >= 7'h10 && !reduced_i
		&& $stable(ain_channel_i)) [*4] |-> line_oe_o[22:20] == 3'h7
		&& line_o[22:20] == ain_channel_i[6:4] - 3'h1) else $error("mux steering");
	a_mask_high_zero: assert property (req_i && !wr_i && addr_i == 16'h0B54
		|=> rdata_o[31:23] == 9'h0) else $error("mask upper bits");
	// main scenarios
	cover property (ack_o && err_o);
	cover property (line_oe_o[22:20] == 3'h7);
	cover property (req_i && wr_i && addr_i == 16'h0B54);
endmodule // dlb_props

/* File: dv/dlb_top_test.sv */
// self-checking bench for the digital line bank
module dlb_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 0, reset_i = 1, reduced_i = 0, req_i = 0, wr_i = 0, ain_active_i = 0;
	logic [15:0] addr_i = 16'h0;
	logic [31:0] wdata_i = 32'h0;
	logic [6:0] ain_channel_i = 7'h0;
	logic [22:0] ext = 23'h0;
	wire ack_o, err_o;
	wire [31:0] rdata_o;
	wire [22:0] line_i, line_o, line_oe_o;
	int errors = 0, check_count = 0;
	logic [31:0] got;
	logic ge;
	logic ga;
	// 50 MHz clock
	always #10 clock_i = ~clock_i;
	dlb_top dlb_top_i(.clock_i, .reset_i, .reduced_i, .req_i, .wr_i, .addr_i, .wdata_i, .ack_o,
		.err_o, .rdata_o, .ain_active_i, .ain_channel_i, .line_i, .line_o, .line_oe_o);
	dlb_partner dlb_partner_i(.drv_i(line_o), .oe_i(line_oe_o), .ext_i(ext), .pin_o(line_i));
	// compare one value
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one register access, answer taken one cycle later
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clock_i);
		req_i <= 1'b1;
		wr_i <= w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		req_i <= 1'b0;
		#1;
		got = rdata_o;
		ge = err_o;
		ga = ack_o;
	endtask
	task end_of_test;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i) reduced_i <= 1'b1;
		acc(1'b1, 16'h07D0, 32'h1);
		chk({9'h0, line_oe_o}, 32'h0);
		@(posedge clock_i) reduced_i <= 1'b0;
		acc(1'b1, 16'h07D4, 32'h1);
		chk({9'h0, line_oe_o}, 32'h10);
		repeat (3) @(posedge clock_i);
		acc(1'b0, 16'h09C4, 32'h0);
		chk(got, 32'h10);
		acc(1'b1, 16'h0B54, 32'hFFFFFFFF);
		acc(1'b0, 16'h0B54, 32'h0);
		chk(got, 32'h7FFFFF);
		acc(1'b1, 16'h0B54, 32'h7FFFCF);
		acc(1'b1, 16'h0B22, 32'h7FFFFF);
		chk({9'h0, line_oe_o}, 32'h30);
		acc(1'b1, 16'h0AF0, 32'h0);
		chk({9'h0, line_o}, 32'h0);
		acc(1'b1, 16'h09C4, 32'h2030);
		chk({9'h0, line_o}, 32'h10);
		chk({9'h0, line_oe_o}, 32'h30);
		acc(1'b0, 16'h07D5, 32'h0);
		chk(got, 32'h0);
		chk({9'h0, line_oe_o}, 32'h10);
		acc(1'b0, 16'h07E7, 32'h0);
		chk({31'h0, ge}, 32'h1);
		chk({31'h0, ga}, 32'h1);
		@(posedge clock_i) ain_active_i <= 1'b1;
		ain_channel_i <= 7'h25;
		repeat (6) @(posedge clock_i);
		#1;
		chk({9'h0, line_oe_o}, 32'h700010);
		chk({9'h0, line_o}, 32'h100010);
		acc(1'b0, 16'h0AF0, 32'h0);
		chk(got, 32'h100010);
		end_of_test;
	end
	// about 40 cycles of tests, limit far beyond that
	initial
	begin
		#100us;
		errors++;
		end_of_test;
	end
endmodule // dlb_top_test
bind dlb_top dlb_props dlb_props_i(.clock_i, .reset_i, .reduced_i, .req_i, .wr_i, .addr_i,
	.wdata_i, .ack_o, .err_o, .rdata_o, .ain_active_i, .ain_channel_i, .line_i, .line_o,
	.line_oe_o);

/* File: rtl/dlb_mux_sel.v */
// steering of the select port from the analog channel number
`include "dlb_regs.vh"
module dlb_mux_sel
(
	// clock and reset
	input wire clock_i,
	input wire reset_i,
	// analog channel in use
	input wire ain_active_i,
	input wire [6:0] ain_channel_i,
	// override outputs
	output reg auto_o,
	output reg [2:0] level_o
);
	// channels 16..127 take over the select lines, channel bits 6:4 less one pick the mux input
	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			auto_o <= 1'b0;
			level_o <= 3'h0;
		end
		else
		begin
			auto_o <= ain_active_i && (ain_channel_i >= `DLB_MUX_CH_LO) &&
				(ain_channel_i <= `DLB_MUX_CH_HI);
			level_o <= ain_channel_i[6:4] - 3'h1;
		end
	end
endmodule // dlb_mux_sel

/* File: rtl/dlb_regs.vh */
// register addresses, field positions and counts for the digital line bank
`ifndef DLB_REGS_VH
`define DLB_REGS_VH
`define DLB_NUM_LINES 23
`define DLB_ADDR_W 16
`define DLB_DATA_W 32
`define DLB_LINE_BASE 16'h07D0
`define DLB_FIRST_BASE 16'h07D0
`define DLB_SECOND_BASE 16'h07D8
`define DLB_NIBBLE_BASE 16'h07E0
`define DLB_SELECT_BASE 16'h07E4
`define DLB_LINE_LAST 16'h07E6
`define DLB_FIRST_LEVELS 16'h09C4
`define DLB_SECOND_LEVELS 16'h09C5
`define DLB_NIBBLE_LEVELS 16'h09C6
`define DLB_SELECT_LEVELS 16'h09C7
`define DLB_BANK_LEVELS 16'h0AF0
`define DLB_BANK_DIR 16'h0B22
`define DLB_BANK_MASK 16'h0B54
`define DLB_FIRST_LSB 0
`define DLB_SECOND_LSB 8
`define DLB_NIBBLE_LSB 16
`define DLB_SELECT_LSB 20
`define DLB_INHIBIT_LSB 8
`define DLB_MUX_CH_LO 7'h10
`define DLB_MUX_CH_HI 7'h7F
`define DLB_REDUCED_FIRST_MASK 23'h00000F
`define DLB_REDUCED_SELECT_MASK 23'h700000
`endif

/* File: rtl/dlb_sync.v */
// two-flop synchroniser for the line terminals
module dlb_sync
(
	// clock and reset
	input wire clock_i,
	input wire reset_i,
	// async terminals and synchronised copy
	input wire [22:0] async_i,
	output reg [22:0] sync_o
);
	reg [22:0] meta_q;

	// first stage is read only by the second
	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			meta_q <= 23'h000000;
			sync_o <= 23'h000000;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // dlb_sync

/* File: rtl/dlb_top.v */
// digital line bank: register file, line drivers and read-back
// Overview of operation
// - a one in the bank write mask keeps that line's bank direction and level unchanged.
// - 23 lines, 0 to 22, with bit n of each bank mask register meaning line n.
// - lines 0-7 first port, 8-15 second port, 16-19 nibble port, 20-22 select port.
// - select port lines follow the analog channel while a channel 16..127 is in use, except on the reduced variant.
// - a single-line register reads the level and a write drives it; any access sets direction.
// - single-line registers sit at 2000 plus line number, port aliases decode the same.
// - bits 15:8 of a port level register write inhibit writes to the matching lines.
// - port level registers at 2500..2503 change levels only, never direction.
// - level reads return the sampled terminal, not the written value.
// - level bits sit at the low end: 8, 8, 4 and 3 bits.
// - on the reduced variant the low first-port bits and the select port are ignored.
// - direction 0 is input, 1 is output; bank direction writes use the mask too.
`include "dlb_regs.vh"
module dlb_top
(
	// clock and reset
	input wire clock_i,
	input wire reset_i,
	// variant strap
	input wire reduced_i,
	// register port
	input wire req_i,
	input wire wr_i,
	input wire [15:0] addr_i,
	input wire [31:0] wdata_i,
	output reg ack_o,
	output reg err_o,
	output reg [31:0] rdata_o,
	// analog channel in use
	input wire ain_active_i,
	input wire [6:0] ain_channel_i,
	// line terminals
	input wire [22:0] line_i,
	output reg [22:0] line_o,
	output reg [22:0] line_oe_o
);
	reg [22:0] dir_q;
	reg [22:0] lvl_q;
	reg [22:0] mask_q;
	reg reduced_q;
	reg [22:0] dir_d;
	reg [22:0] lvl_d;
	reg [22:0] mask_d;
	reg [31:0] rdata_d;
	reg hit_d;
	wire [22:0] pin_sync;
	wire mux_auto;
	wire [2:0] mux_level;
	wire [22:0] keep_mask;
	wire [4:0] line_idx;

	// port field of a 23-bit vector into the low bits of a word
	function [31:0] port_read;
		input [22:0] v;
		input [1:0] port;
		begin
			case (port)
				2'd0: port_read = {24'h000000, v[7:0]};
				2'd1: port_read = {24'h000000, v[15:8]};
				2'd2: port_read = {28'h0000000, v[19:16]};
				default: port_read = {29'h00000000, v[22:20]};
			endcase
		end
	endfunction

	// per-line enable for a port write: field bits not inhibited
	function [22:0] port_en;
		input [31:0] w;
		input [1:0] port;
		reg [7:0] en;
		begin
			en = ~w[15:8];
			case (port)
				2'd0: port_en = {15'h0000, en};
				2'd1: port_en = {7'h00, en, 8'h00};
				2'd2: port_en = {3'h0, en[3:0], 16'h0000};
				default: port_en = {en[2:0], 20'h00000};
			endcase
		end
	endfunction

	// port levels shifted to line positions
	function [22:0] port_put;
		input [31:0] w;
		input [1:0] port;
		begin
			case (port)
				2'd0: port_put = {15'h0000, w[7:0]};
				2'd1: port_put = {7'h00, w[7:0], 8'h00};
				2'd2: port_put = {3'h0, w[3:0], 16'h0000};
				default: port_put = {w[2:0], 20'h00000};
			endcase
		end
	endfunction

	dlb_sync u_sync
	(
		.clock_i(clock_i),
		.reset_i(reset_i),
		.async_i(line_i),
		.sync_o(pin_sync)
	);

	dlb_mux_sel u_mux
	(
		.clock_i(clock_i),
		.reset_i(reset_i),
		.ain_active_i(ain_active_i),
		.ain_channel_i(ain_channel_i),
		.auto_o(mux_auto),
		.level_o(mux_level)
	);

	// lines the reduced variant leaves untouched
	assign keep_mask = reduced_q ? (`DLB_REDUCED_FIRST_MASK | `DLB_REDUCED_SELECT_MASK) :
		23'h000000;
	assign line_idx = addr_i[4:0] - 5'h10; // 0x7D0 has low bits 1_0000

	// strap captured by a clocked process
	always @(posedge clock_i)
	begin
		if (reset_i)
			reduced_q <= 1'b0;
		else
			reduced_q <= reduced_i;
	end

	// register write decode
	always @*
	begin
		dir_d = dir_q;
		lvl_d = lvl_q;
		mask_d = mask_q;
		if (req_i && wr_i)
		begin
			if (addr_i >= `DLB_LINE_BASE && addr_i <= `DLB_LINE_LAST)
			begin
				// single line: level and output direction, same register via alias
				lvl_d[line_idx] = wdata_i[0];
				dir_d[line_idx] = 1'b1;
			end
			else if (addr_i >= `DLB_FIRST_LEVELS && addr_i <= `DLB_SELECT_LEVELS)
			begin
				// levels only, inhibit byte gates lines
				lvl_d = (lvl_q & ~port_en(wdata_i, addr_i[1:0])) |
					(port_put(wdata_i, addr_i[1:0]) &
					port_en(wdata_i, addr_i[1:0]));
			end
			else if (addr_i == `DLB_BANK_MASK)
				mask_d = wdata_i[22:0];
			else if (addr_i == `DLB_BANK_DIR)
				dir_d = (dir_q & mask_q) | (wdata_i[22:0] & ~mask_q);
			else if (addr_i == `DLB_BANK_LEVELS)
				lvl_d = (lvl_q & mask_q) | (wdata_i[22:0] & ~mask_q);
		end
		else if (req_i && addr_i >= `DLB_LINE_BASE && addr_i <= `DLB_LINE_LAST)
			dir_d[line_idx] = 1'b0; // read of a line makes it an input
		// reduced variant never changes the ignored lines
		dir_d = (dir_d & ~keep_mask) | (dir_q & keep_mask);
		lvl_d = (lvl_d & ~keep_mask) | (lvl_q & keep_mask);
	end

	// register read decode, levels from the terminals
	always @*
	begin
		rdata_d = 32'h00000000;
		hit_d = 1'b1;
		if (addr_i >= `DLB_LINE_BASE && addr_i <= `DLB_LINE_LAST)
			rdata_d = {31'h00000000, pin_sync[line_idx]};
		else if (addr_i >= `DLB_FIRST_LEVELS && addr_i <= `DLB_SELECT_LEVELS)
			rdata_d = port_read(pin_sync, addr_i[1:0]);
		else if (addr_i == `DLB_BANK_MASK)
			rdata_d = {9'h000, mask_q};
		else if (addr_i == `DLB_BANK_DIR)
			rdata_d = {9'h000, dir_q};
		else if (addr_i == `DLB_BANK_LEVELS)
			rdata_d = {9'h000, pin_sync};
		else
			hit_d = 1'b0;
	end

	// state registers and answer
	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			dir_q <= 23'h000000;
			lvl_q <= 23'h000000;
			mask_q <= 23'h000000;
			ack_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= 32'h00000000;
		end
		else
		begin
			dir_q <= dir_d;
			lvl_q <= lvl_d;
			mask_q <= mask_d;
			ack_o <= req_i;
			err_o <= req_i && !hit_d;
			rdata_o <= (req_i && !wr_i) ? rdata_d : 32'h00000000;
		end
	end

	// pin drivers, select port overridden by analog steering
	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			line_o <= 23'h000000;
			line_oe_o <= 23'h000000;
		end
		else if (mux_auto && !reduced_q)
		begin
			line_o <= {mux_level, lvl_d[19:0]};
			line_oe_o <= {3'h7, dir_d[19:0]};
		end
		else
		begin
			line_o <= lvl_d;
			line_oe_o <= dir_d & ~keep_mask;
		end
	end
endmodule // dlb_top
